// ### logic/eipa_pkg.sv
// package of constants and types for the external interrupt priority arbiter
// ****************************************
// Overview of operation
// ****************************************
package eipa_pkg;
  localparam int DW = 16;
  localparam int AW = 4;
  // register offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_PRIO_A = 4'h1;
  localparam logic [3:0] OFF_PRIO_B = 4'h2;
  localparam logic [3:0] OFF_PRIO_C = 4'h3;
  localparam logic [3:0] OFF_PRIO_D = 4'h4;
  localparam logic [3:0] OFF_PRIO_E = 4'h5;
  localparam logic [3:0] OFF_STAT = 4'h6;
  // control register fields
  localparam int NMI_LVL_BIT = 15;
  localparam int NMI_EDGE_BIT = 8;
  localparam logic [15:0] CTRL_WMASK = 16'h01ff;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PRIO_RST = 16'h0000;
  localparam logic [15:0] PRIO_E_WMASK = 16'hfff0;
  // sources: 0 nonmaskable, 1..8 pins, 9.. on-chip
  localparam int NPIN = 8;
  localparam int NCHIP = 12;
  localparam int NSRC = 1 + NPIN + NCHIP;
  localparam logic [3:0] NMI_LEVEL = 4'hf;
  localparam logic [4:0] NO_SRC = 5'h1f;
  // pipeline depths in states
  localparam int DEC_CHIP = 2;
  localparam int DEC_PIN = 3;
  localparam int ENTRY_BASE = 5;
  localparam logic [7:0] VEC_NMI = 8'h0b;
  localparam logic [7:0] VEC_PIN0 = 8'h40;
  localparam logic [7:0] VEC_CHIP0 = 8'h48;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } eipa_bus_t;

  typedef struct packed {
    logic valid;
    logic [3:0] level;
    logic [7:0] vector;
    logic [4:0] src;
  } eipa_req_t;
endpackage

// ### logic/eipa_arbiter.sv
// external interrupt priority arbiter core
`timescale 1ns/1ps
module eipa_arbiter #(
  parameter int NCHIP = eipa_pkg::NCHIP
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // register port
  input wire eipa_pkg::eipa_bus_t i_bus,
  output logic [15:0] o_rdata,
  // request sources
  input wire logic i_nonmaskable_pin,
  input wire logic [7:0] i_external_request_pins_n,
  input wire logic [NCHIP-1:0] i_chip_req,
  // cpu side
  input wire logic [3:0] i_mask_level_field,
  input wire logic i_cpu_seq_busy,
  input wire logic i_cpu_take,
  input wire logic i_cpu_mask_upd,
  output eipa_pkg::eipa_req_t o_cpu_req,
  output logic o_acceptance_output_pin
);

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] ctrl_ff;
  logic [15:0] prio_ff [5];
  logic nmi_s1_ff, nmi_s2_ff, nmi_s3_ff;
  logic [7:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic nmi_pend_ff;
  logic [7:0] edge_pend_ff;
  logic [1:0] pin_dly_ff;
  eipa_pkg::eipa_req_t sel_ff;
  eipa_pkg::eipa_req_t acc_ff;
  logic acc_edge_ff;
  logic irq_out_n_ff;

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_ff <= eipa_pkg::CTRL_RST;
      for (int k = 0; k < 5; k++)
      begin
        prio_ff[k] <= eipa_pkg::PRIO_RST;
      end
    end
    else if (i_bus.wr)
    begin
      if (i_bus.addr == eipa_pkg::OFF_CTRL)
      begin
        ctrl_ff <= i_bus.wdata & eipa_pkg::CTRL_WMASK;
      end
      else if (i_bus.addr == eipa_pkg::OFF_PRIO_A)
      begin
        prio_ff[0] <= i_bus.wdata;
      end
      else if (i_bus.addr == eipa_pkg::OFF_PRIO_B)
      begin
        prio_ff[1] <= i_bus.wdata;
      end
      else if (i_bus.addr == eipa_pkg::OFF_PRIO_C)
      begin
        prio_ff[2] <= i_bus.wdata;
      end
      else if (i_bus.addr == eipa_pkg::OFF_PRIO_D)
      begin
        prio_ff[3] <= i_bus.wdata;
      end
      else if (i_bus.addr == eipa_pkg::OFF_PRIO_E)
      begin
        prio_ff[4] <= i_bus.wdata & eipa_pkg::PRIO_E_WMASK;
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [15:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (i_bus.addr == eipa_pkg::OFF_CTRL)
    begin
      nxt_rdata = ctrl_ff;
      nxt_rdata[eipa_pkg::NMI_LVL_BIT] = nmi_s2_ff;
    end
    else if (i_bus.addr == eipa_pkg::OFF_PRIO_A)
    begin
      nxt_rdata = prio_ff[0];
    end
    else if (i_bus.addr == eipa_pkg::OFF_PRIO_B)
    begin
      nxt_rdata = prio_ff[1];
    end
    else if (i_bus.addr == eipa_pkg::OFF_PRIO_C)
    begin
      nxt_rdata = prio_ff[2];
    end
    else if (i_bus.addr == eipa_pkg::OFF_PRIO_D)
    begin
      nxt_rdata = prio_ff[3];
    end
    else if (i_bus.addr == eipa_pkg::OFF_PRIO_E)
    begin
      nxt_rdata = prio_ff[4];
    end
    else if (i_bus.addr == eipa_pkg::OFF_STAT)
    begin
      nxt_rdata = {7'h00, acc_ff.valid, acc_ff.level, 4'h0};
      nxt_rdata[3:0] = sel_ff.level;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rdata <= 16'h0000;
    end
    else
    begin
      o_rdata <= i_bus.rd ? nxt_rdata : 16'h0000;
    end
  end

  // ****************************************
  // pin sampling and edge detection
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      nmi_s1_ff <= 1'b1;
      nmi_s2_ff <= 1'b1;
      nmi_s3_ff <= 1'b1;
      pin_s1_ff <= 8'hff;
      pin_s2_ff <= 8'hff;
      pin_s3_ff <= 8'hff;
    end
    else
    begin
      nmi_s1_ff <= i_nonmaskable_pin;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_s3_ff <= nmi_s2_ff;
      pin_s1_ff <= i_external_request_pins_n;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  logic nmi_edge;
  assign nmi_edge = ctrl_ff[eipa_pkg::NMI_EDGE_BIT] ? (nmi_s2_ff & ~nmi_s3_ff)
                                                    : (~nmi_s2_ff & nmi_s3_ff);

  logic take_nmi;
  logic [7:0] take_pin;
  logic [7:0] pin_req;

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      nmi_pend_ff <= 1'b0;
    end
    else if (nmi_edge)
    begin
      nmi_pend_ff <= 1'b1;
    end
    else if (take_nmi)
    begin
      nmi_pend_ff <= 1'b0;
    end
  end

  // pin k sensed by control bit 7-k
  for (genvar k = 0; k < eipa_pkg::NPIN; k++)
  begin : g_pin
    logic edge_mode;
    assign edge_mode = ctrl_ff[7-k];
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
      if (!i_nrst)
      begin
        edge_pend_ff[k] <= 1'b0;
      end
      else if (edge_mode && !pin_s2_ff[k] && pin_s3_ff[k])
      begin
        edge_pend_ff[k] <= 1'b1;
      end
      else if (take_pin[k] || !edge_mode)
      begin
        edge_pend_ff[k] <= 1'b0;
      end
    end
    assign pin_req[k] = edge_mode ? edge_pend_ff[k] : ~pin_s2_ff[k];
  end

  // ****************************************
  // priority selection
  // ****************************************
  logic [3:0] src_lvl [eipa_pkg::NSRC];
  logic [eipa_pkg::NSRC-1:0] src_req;
  always_comb
  begin
    src_lvl[0] = eipa_pkg::NMI_LEVEL;
    src_req[0] = nmi_pend_ff;
    for (int k = 0; k < eipa_pkg::NPIN; k++)
    begin
      src_lvl[1+k] = prio_ff[k/4][15-4*(k%4) -: 4];
      src_req[1+k] = pin_req[k];
    end
    for (int k = 0; k < eipa_pkg::NCHIP; k++)
    begin
      src_lvl[1+eipa_pkg::NPIN+k] = prio_ff[2+k/4][15-4*(k%4) -: 4];
      src_req[1+eipa_pkg::NPIN+k] = i_chip_req[k];
    end
  end

  eipa_pkg::eipa_req_t best;
  always_comb
  begin
    best = '0;
    best.src = eipa_pkg::NO_SRC;
    // lower index wins ties
    for (int k = eipa_pkg::NSRC-1; k >= 0; k--)
    begin
      if (src_req[k] && (!best.valid || src_lvl[k] >= best.level))
      begin
        best.valid = 1'b1;
        best.level = src_lvl[k];
        best.src = 5'(k);
        if (k == 0)
        begin
          best.vector = eipa_pkg::VEC_NMI;
        end
        else if (k <= eipa_pkg::NPIN)
        begin
          best.vector = eipa_pkg::VEC_PIN0 + 8'(k-1);
        end
        else
        begin
          best.vector = eipa_pkg::VEC_CHIP0 + 8'(k-1-eipa_pkg::NPIN);
        end
      end
    end
  end

  // ****************************************
  // decision pipeline and acceptance
  // ****************************************
  logic is_pin_sel;
  logic dec_done;
  logic accept;
  assign is_pin_sel = sel_ff.valid && sel_ff.src != 5'd0
                      && sel_ff.src <= 5'(eipa_pkg::NPIN);
  // pin requests spend an extra state
  assign dec_done = sel_ff.valid && (!is_pin_sel || pin_dly_ff == 2'(eipa_pkg::DEC_PIN-2));
  assign accept = dec_done && !i_cpu_seq_busy && (sel_ff.level > i_mask_level_field)
                  && (!acc_ff.valid || sel_ff.level > acc_ff.level);

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sel_ff <= '0;
      pin_dly_ff <= 2'd0;
    end
    else
    begin
      sel_ff <= best;
      pin_dly_ff <= (best.valid && best.src == sel_ff.src && is_pin_sel) ? 2'd1 : 2'd0;
    end
  end

  always_comb
  begin
    take_nmi = i_cpu_take && acc_ff.valid && acc_ff.src == 5'd0;
    take_pin = 8'h00;
    for (int k = 0; k < eipa_pkg::NPIN; k++)
    begin
      take_pin[k] = i_cpu_take && acc_ff.valid && acc_ff.src == 5'(k+1);
    end
  end

  logic nxt_acc_edge;
  assign nxt_acc_edge = (sel_ff.src == 5'd0)
                        || (is_pin_sel && ctrl_ff[7 - (32'(sel_ff.src) - 1)]);

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      acc_ff <= '0;
      acc_edge_ff <= 1'b0;
      irq_out_n_ff <= 1'b1;
    end
    else if (accept)
    begin
      acc_ff <= sel_ff;
      acc_edge_ff <= nxt_acc_edge;
      irq_out_n_ff <= 1'b0;
    end
    else if (acc_ff.valid && ((acc_edge_ff && i_cpu_take) || (!acc_edge_ff && i_cpu_mask_upd)))
    begin
      acc_ff.valid <= 1'b0;
      irq_out_n_ff <= 1'b1;
    end
  end

  // cpu loads level into mask, pushes state, fetches vector
  assign o_cpu_req = acc_ff;
  assign o_acceptance_output_pin = irq_out_n_ff;

endmodule // eipa_arbiter

// ### testbench/eipa_arbiter_properties.sv
// port assertions for the arbiter
`timescale 1ns/1ps
module eipa_arbiter_properties #(
  parameter int NCHIP = eipa_pkg::NCHIP
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // register port
  input wire eipa_pkg::eipa_bus_t i_bus,
  input wire logic [15:0] o_rdata,
  // request sources
  input wire logic i_nonmaskable_pin,
  input wire logic [7:0] i_external_request_pins_n,
  input wire logic [NCHIP-1:0] i_chip_req,
  // cpu side
  input wire logic [3:0] i_mask_level_field,
  input wire logic i_cpu_seq_busy,
  input wire logic i_cpu_take,
  input wire logic i_cpu_mask_upd,
  input wire eipa_pkg::eipa_req_t o_cpu_req,
  input wire logic o_acceptance_output_pin
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  sequence s_rd(logic [3:0] a);
    i_bus.rd && i_bus.addr == a;
  endsequence
  sequence s_accept;
    $rose(o_cpu_req.valid);
  endsequence
  a_ctrl_reserved_zero:
    assert property (s_rd(eipa_pkg::OFF_CTRL) |=> o_rdata[14:9] == 6'h00)
    else $error("reserved control bits read nonzero");
  a_prio_reserved_zero:
    assert property (s_rd(eipa_pkg::OFF_PRIO_E) |=> o_rdata[3:0] == 4'h0)
    else $error("reserved priority bits read nonzero");
  a_accept_pin_low:
    assert property (o_cpu_req.valid |-> !o_acceptance_output_pin)
    else $error("acceptance pin high while request forwarded");
  a_above_mask_only:
    assert property (s_accept |-> o_cpu_req.level > $past(i_mask_level_field))
    else $error("request forwarded at or below mask");
  a_wait_cpu_idle:
    assert property (s_accept |-> !$past(i_cpu_seq_busy))
    else $error("request accepted while cpu busy");
  a_level_release:
    assert property (i_cpu_mask_upd && o_cpu_req.src >= 5'h09 |=>
      o_acceptance_output_pin || o_cpu_req.level > $past(o_cpu_req.level))
    else $error("acceptance pin not released at mask update");
  a_nmi_take_release:
    assert property (i_cpu_take && o_cpu_req.valid && o_cpu_req.src == 5'h00 |=>
      o_acceptance_output_pin)
    else $error("acceptance pin not released at take");
  a_nmi_fixed_level:
    assert property (o_cpu_req.valid && o_cpu_req.src == 5'h00 |->
      o_cpu_req.level == eipa_pkg::NMI_LEVEL && o_cpu_req.vector == eipa_pkg::VEC_NMI)
    else $error("nonmaskable request level or vector wrong");
  a_vector_map:
    assert property (o_cpu_req.valid && o_cpu_req.src != 5'h00 |->
      o_cpu_req.vector == ((o_cpu_req.src >= 5'h09)
        ? eipa_pkg::VEC_CHIP0 + 8'(o_cpu_req.src - 5'h09)
        : eipa_pkg::VEC_PIN0 + 8'(o_cpu_req.src - 5'h01)))
    else $error("request vector does not match source");
endmodule // eipa_arbiter_properties

bind eipa_arbiter eipa_arbiter_properties #(.NCHIP(NCHIP)) props_u (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_nonmaskable_pin(i_nonmaskable_pin), .i_external_request_pins_n(i_external_request_pins_n),
  .i_chip_req(i_chip_req), .i_mask_level_field(i_mask_level_field),
  .i_cpu_seq_busy(i_cpu_seq_busy), .i_cpu_take(i_cpu_take), .i_cpu_mask_upd(i_cpu_mask_upd),
  .o_cpu_req(o_cpu_req), .o_acceptance_output_pin(o_acceptance_output_pin)
);

// ### testbench/eipa_cpu_model.sv
// cpu model taking forwarded requests
`timescale 1ns/1ps
module eipa_cpu_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // arbiter side
  input wire eipa_pkg::eipa_req_t i_req,
  output logic [3:0] o_mask,
  output logic o_busy,
  output logic o_take,
  output logic o_upd,
  // bench side
  input wire logic i_set,
  input wire logic [3:0] i_mask,
  input wire logic [3:0] i_delay,
  output logic [3:0] o_entries,
  output logic [4:0] o_src
);
  logic [4:0] step_ff;
  logic [3:0] lvl_ff;
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      {step_ff, lvl_ff, o_mask, o_busy, o_take, o_upd, o_entries, o_src} <= '0;
    end
    else
    begin
      o_take <= 1'b0;
      o_upd <= 1'b0;
      if (i_set)
        o_mask <= i_mask;
      if (step_ff != 5'h00)
        step_ff <= step_ff + 5'h01;
      else if (i_req.valid && !o_busy)
        step_ff <= 5'h01;
      if (step_ff == 5'(i_delay) + 5'h01)
      begin
        o_take <= 1'b1;
        lvl_ff <= i_req.level;
        o_src <= i_req.src;
      end
      if (step_ff == 5'(i_delay) + 5'h02)
      begin
        o_upd <= 1'b1;
        o_mask <= lvl_ff;
        o_busy <= 1'b1;
      end
      if (step_ff == 5'(i_delay) + 5'h0a)
      begin
        o_busy <= 1'b0;
        step_ff <= 5'h00;
        o_entries <= o_entries + 4'h1;
      end
    end
  end
endmodule // eipa_cpu_model

// ### testbench/external_interrupt_priority_arbiter_tb.sv
// self-checking bench for the arbiter
`timescale 1ns/1ps
module external_interrupt_priority_arbiter_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  eipa_pkg::eipa_bus_t bus = '0;
  logic nmi = 1'b1;
  logic [7:0] pins_n = 8'hff;
  logic [11:0] chip = 12'h000;
  logic set = 1'b0;
  logic [3:0] msk = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [15:0] rdata;
  eipa_pkg::eipa_req_t req;
  logic acc, busy, take, upd;
  logic [3:0] mask, ents;
  logic [4:0] src;
  int fail_count = 0;
  int num_checks = 0;
  int n_ent = 0;
  always #4 ref_clk = ~ref_clk;
  eipa_arbiter dut_u (
    .i_ref_clk(ref_clk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata),
    .i_nonmaskable_pin(nmi), .i_external_request_pins_n(pins_n), .i_chip_req(chip),
    .i_mask_level_field(mask), .i_cpu_seq_busy(busy), .i_cpu_take(take),
    .i_cpu_mask_upd(upd), .o_cpu_req(req), .o_acceptance_output_pin(acc)
  );
  eipa_cpu_model cpu_u (
    .i_ref_clk(ref_clk), .i_nrst(nrst), .i_req(req), .o_mask(mask), .o_busy(busy),
    .o_take(take), .o_upd(upd), .i_set(set), .i_mask(msk), .i_delay(dly),
    .o_entries(ents), .o_src(src)
  );
  task automatic summarize();
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    cyc(1);
    bus <= '0;
    #1 chk(rdata, e);
    cyc(1);
  endtask
  task automatic mask_to(input logic [3:0] v);
    set <= 1'b1;
    msk <= v;
    cyc(1);
    set <= 1'b0;
    cyc(1);
  endtask
  task automatic entered(input logic [4:0] s);
    int i;
    i = 0;
    n_ent++;
    while (ents !== 4'(n_ent) && i < 40)
    begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    chk({12'h000, ents}, 16'(n_ent));
    chk({11'h000, src}, {11'h000, s});
    cyc(1);
  endtask
  initial
  begin
    #400000;
    fail_count++;
    summarize();
  end
  initial
  begin
    cyc(6);
    nrst <= 1'b1;
    cyc(3);
    for (int a = 0; a < 8; a++)
      rd(4'(a), (a == 0) ? 16'h8000 : 16'h0000);
    wr(eipa_pkg::OFF_CTRL, 16'h01ff);
    rd(eipa_pkg::OFF_CTRL, 16'h81ff);
    wr(eipa_pkg::OFF_PRIO_E, 16'hffff);
    rd(eipa_pkg::OFF_PRIO_E, 16'hfff0);
    wr(eipa_pkg::OFF_CTRL, 16'h0000);
    wr(eipa_pkg::OFF_PRIO_C, 16'h6000);
    mask_to(4'h6);
    chip <= 12'h001;
    cyc(8);
    chk(16'(acc), 16'h0001);
    rd(eipa_pkg::OFF_STAT, 16'h0006);
    chip <= 12'h000;
    mask_to(4'h5);
    chip <= 12'h001;
    @(posedge ref_clk);
    #1 chk(16'(acc), 16'h0001);
    @(posedge ref_clk);
    #1 chk(16'(acc), 16'h0000);
    entered(5'h09);
    chk(16'(mask), 16'h0006);
    mask_to(4'h0);
    entered(5'h09);
    chip <= 12'h000;
    mask_to(4'h0);
    dly <= 4'h3;
    wr(eipa_pkg::OFF_PRIO_A, 16'h3400);
    pins_n <= 8'hfc;
    entered(5'h02);
    pins_n <= 8'hff;
    wr(eipa_pkg::OFF_PRIO_A, 16'h4400);
    mask_to(4'h0);
    pins_n <= 8'hfc;
    entered(5'h01);
    pins_n <= 8'hff;
    wr(eipa_pkg::OFF_PRIO_A, 16'h0050);
    mask_to(4'hf);
    pins_n <= 8'hfb;
    cyc(5);
    pins_n <= 8'hff;
    cyc(5);
    mask_to(4'h0);
    cyc(30);
    chk({12'h000, ents}, 16'(n_ent));
    wr(eipa_pkg::OFF_CTRL, 16'h0020);
    mask_to(4'hf);
    repeat (2)
    begin
      pins_n <= 8'hfb;
      cyc(4);
      pins_n <= 8'hff;
      cyc(4);
    end
    mask_to(4'h0);
    entered(5'h03);
    mask_to(4'h0);
    cyc(30);
    chk({12'h000, ents}, 16'(n_ent));
    nmi <= 1'b0;
    entered(5'h00);
    chk(16'(mask), 16'h000f);
    wr(eipa_pkg::OFF_CTRL, 16'h8020);
    rd(eipa_pkg::OFF_CTRL, 16'h0020);
    wr(eipa_pkg::OFF_CTRL, 16'h0120);
    mask_to(4'h0);
    nmi <= 1'b1;
    entered(5'h00);
    summarize();
  end
endmodule // external_interrupt_priority_arbiter_tb
